//--- sgs_pkg.sv
// constants, register map and carrier types of the servo gain group selector
// Functional notes
// - feedforward source codes: none, internal, external
// - feedforward gain 0..1000 in 0.1 percent
// - feedforward filter time 0..6400, default zero
// - input function: p/pi toggle or set toggle
// - codes 0 and 1 fix set one/two
// - code 2 follows gain select input
// - position code 3 compares torque command
// - position code 5 compares speed command
// - position code 6 compares position deviation
// - position code 7 follows position command activity
// - position code 8 follows positioning completion
// - position code 9 compares speed feedback
// - position code 10 needs command zero, speed low
// - position delay default 50, levels to 20000
// - speed code 3 compares torque command
// - speed code 4 compares speed command change
// - speed code 5 compares speed command
// - speed mode own delay, level, hysteresis
// - torque code 3 compares torque command
// - torque mode own settings, codes 0..3
// - observer cutoff 0..500, default 100, restart
// - observer inertia default 1000, 1024 recommended
package sgs_pkg;
  localparam logic [7:0] OFS_SOURCE = 8'h00;
  localparam logic [7:0] OFS_FF_GAIN = 8'h04;
  localparam logic [7:0] OFS_FF_FILT = 8'h08;
  localparam logic [7:0] OFS_IN_FUNC = 8'h0c;
  localparam logic [7:0] OFS_POS_MODE = 8'h10;
  localparam logic [7:0] OFS_POS_DLY = 8'h14;
  localparam logic [7:0] OFS_POS_LVL = 8'h18;
  localparam logic [7:0] OFS_POS_HYS = 8'h1c;
  localparam logic [7:0] OFS_POS_TIME = 8'h20;
  localparam logic [7:0] OFS_SPD_MODE = 8'h24;
  localparam logic [7:0] OFS_SPD_DLY = 8'h28;
  localparam logic [7:0] OFS_SPD_LVL = 8'h2c;
  localparam logic [7:0] OFS_SPD_HYS = 8'h30;
  localparam logic [7:0] OFS_TRQ_MODE = 8'h34;
  localparam logic [7:0] OFS_TRQ_DLY = 8'h38;
  localparam logic [7:0] OFS_TRQ_LVL = 8'h3c;
  localparam logic [7:0] OFS_TRQ_HYS = 8'h40;
  localparam logic [7:0] OFS_OBS_MODE = 8'h44;
  localparam logic [7:0] OFS_OBS_CUT = 8'h48;
  localparam logic [7:0] OFS_OBS_PH = 8'h4c;
  localparam logic [7:0] OFS_OBS_INR = 8'h50;
  localparam logic [7:0] OFS_STATUS = 8'h54;
  localparam logic [7:0] OFS_RESTART = 8'h58;
  localparam int NREG = 21;
  localparam logic [15:0] RST_POS_DLY = 16'h0032;
  localparam logic [15:0] RST_POS_LVL = 16'h0032;
  localparam logic [15:0] RST_POS_HYS = 16'h0021;
  localparam logic [15:0] RST_POS_TIME = 16'h0021;
  localparam logic [15:0] RST_OBS_CUT = 16'h0064;
  localparam logic [15:0] RST_OBS_INR = 16'h03e8;
  localparam logic [15:0] MAX_FF_GAIN = 16'h03e8;
  localparam logic [15:0] MAX_FF_FILT = 16'h1900;
  localparam logic [15:0] MAX_DLY = 16'h03e8;
  localparam logic [15:0] MAX_LVL = 16'h4e20;
  localparam logic [15:0] MAX_CUT = 16'h01f4;
  localparam logic [15:0] MAX_INR = 16'h2710;
  localparam logic [15:0] MAX_POS_MODE = 16'h000a;
  localparam logic [15:0] MAX_SPD_MODE = 16'h0005;
  localparam logic [15:0] MAX_TRQ_MODE = 16'h0003;
  localparam logic [15:0] MAX_SOURCE = 16'h0002;
  localparam logic [15:0] MAX_OBS_MODE = 16'h0002;
  // delay tick: 0.1 ms at 50 MHz
  localparam int CLK_HZ = 50000000;
  localparam int TICK_US = 100;
  localparam logic [12:0] TICK_CYC = 13'(CLK_HZ / 1000000 * TICK_US);
  localparam logic [1:0] FF_NONE = 2'h0;
  localparam logic [1:0] FF_INTERNAL = 2'h1;
  localparam logic [1:0] FF_EXTERNAL = 2'h2;
  localparam logic [3:0] SW_FIX1 = 4'h0;
  localparam logic [3:0] SW_FIX2 = 4'h1;
  localparam logic [3:0] SW_INPUT = 4'h2;
  localparam logic [3:0] SW_TORQUE = 4'h3;
  localparam logic [3:0] SW_SPD_CHG = 4'h4;
  localparam logic [3:0] SW_SPD_CMD = 4'h5;
  localparam logic [3:0] SW_DEVIATION = 4'h6;
  localparam logic [3:0] SW_POS_CMD = 4'h7;
  localparam logic [3:0] SW_INPOS = 4'h8;
  localparam logic [3:0] SW_SPD_FB = 4'h9;
  localparam logic [3:0] SW_POS_SPD = 4'ha;
  typedef enum logic [1:0] {CTL_POSITION, CTL_SPEED, CTL_TORQUE} sgs_ctl_mode_t;
  typedef struct packed {
    logic [15:0] torque_cmd;
    logic [15:0] speed_cmd;
    logic [15:0] speed_cmd_change;
    logic [15:0] position_dev;
    logic [15:0] speed_fb;
    logic pos_cmd_active;
    logic positioning_done;
    logic gain_sel_in;
  } sgs_monitor_t;
  typedef struct packed {
    logic gain_set2;
    logic speed_p_only;
    logic [1:0] ff_source;
    logic [15:0] ff_gain;
    logic [15:0] ff_filter_time;
    logic [15:0] ff_external;
  } sgs_gain_out_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [15:0] cutoff;
    logic [15:0] phase_comp;
    logic [15:0] inertia;
  } sgs_observer_t;
endpackage

//--- sgs_selector.sv
// servo gain group selector with axi4-lite register slave
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module sgs_selector (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sgs_pkg::sgs_ctl_mode_t ctl_mode,
  input wire logic cycle_strobe,
  input wire sgs_pkg::sgs_monitor_t mon,
  input wire logic [15:0] external_torque_ff_input,
  output sgs_pkg::sgs_gain_out_t gain_out,
  output sgs_pkg::sgs_observer_t observer_out
);
  import sgs_pkg::*;

  logic [15:0] regs_reg [NREG];
  sgs_observer_t obs_live_reg;
  logic restart_req;
  // write channel
  logic aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire wr_ok = (aw_addr_reg[1:0] == 2'b00) && (aw_addr_reg <= OFS_RESTART);
  wire [4:0] wr_idx = aw_addr_reg[6:2];
  wire [15:0] wr_val = {w_strb_reg[1] ? w_data_reg[15:8] : regs_reg[wr_idx][15:8],
                        w_strb_reg[0] ? w_data_reg[7:0] : regs_reg[wr_idx][7:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= (s_axi_awaddr[31:8] == 24'h00_0000) ? s_axi_awaddr[7:0] : 8'hff;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

  // per-register limit; out-of-range writes saturate
  function automatic logic [15:0] reg_max(input int i);
    logic [7:0] a;
    a = 8'(i * 4);
    if (a == OFS_SOURCE) return MAX_SOURCE;
    else if (a == OFS_FF_GAIN) return MAX_FF_GAIN;
    else if (a == OFS_FF_FILT) return MAX_FF_FILT;
    else if (a == OFS_IN_FUNC) return 16'h0001;
    else if (a == OFS_POS_MODE) return MAX_POS_MODE;
    else if (a == OFS_SPD_MODE) return MAX_SPD_MODE;
    else if (a == OFS_TRQ_MODE) return MAX_TRQ_MODE;
    else if (a == OFS_POS_DLY || a == OFS_SPD_DLY || a == OFS_TRQ_DLY) return MAX_DLY;
    else if (a == OFS_POS_TIME) return MAX_DLY;
    else if (a == OFS_OBS_MODE) return MAX_OBS_MODE;
    else if (a == OFS_OBS_CUT) return MAX_CUT;
    else if (a == OFS_OBS_PH || a == OFS_OBS_INR) return MAX_INR;
    else return MAX_LVL;
  endfunction

  function automatic logic [15:0] reg_rst(input int i);
    logic [7:0] a;
    a = 8'(i * 4);
    if (a == OFS_POS_DLY) return RST_POS_DLY;
    else if (a == OFS_POS_LVL) return RST_POS_LVL;
    else if (a == OFS_POS_HYS) return RST_POS_HYS;
    else if (a == OFS_POS_TIME) return RST_POS_TIME;
    else if (a == OFS_OBS_CUT) return RST_OBS_CUT;
    else if (a == OFS_OBS_INR) return RST_OBS_INR;
    else return 16'h0000;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      wire hit = wr_fire && wr_ok && (wr_idx == 5'(gi));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          regs_reg[gi] <= reg_rst(gi);
        end else if (hit) begin
          regs_reg[gi] <= (wr_val > reg_max(gi)) ? reg_max(gi) : wr_val;
        end
      end
    end
  endgenerate
  assign restart_req = wr_fire && (aw_addr_reg == OFS_RESTART) && w_strb_reg[0] && w_data_reg[0];

  // register fields
  wire [1:0] ff_src = regs_reg[OFS_SOURCE[6:2]][1:0];
  wire in_func = regs_reg[OFS_IN_FUNC[6:2]][0];
  wire [3:0] pos_mode = regs_reg[OFS_POS_MODE[6:2]][3:0];
  wire [3:0] spd_mode = regs_reg[OFS_SPD_MODE[6:2]][3:0];
  wire [3:0] trq_mode = regs_reg[OFS_TRQ_MODE[6:2]][3:0];

  // only the active mode's selector counts
  logic [3:0] act_mode;
  logic [15:0] act_dly, act_lvl, act_hys;
  assign act_mode = (ctl_mode == CTL_SPEED) ? spd_mode :
                    (ctl_mode == CTL_TORQUE) ? trq_mode : pos_mode;
  assign act_dly = (ctl_mode == CTL_SPEED) ? regs_reg[OFS_SPD_DLY[6:2]] :
                   (ctl_mode == CTL_TORQUE) ? regs_reg[OFS_TRQ_DLY[6:2]] :
                   regs_reg[OFS_POS_DLY[6:2]];
  assign act_lvl = (ctl_mode == CTL_SPEED) ? regs_reg[OFS_SPD_LVL[6:2]] :
                   (ctl_mode == CTL_TORQUE) ? regs_reg[OFS_TRQ_LVL[6:2]] :
                   regs_reg[OFS_POS_LVL[6:2]];
  assign act_hys = (ctl_mode == CTL_SPEED) ? regs_reg[OFS_SPD_HYS[6:2]] :
                   (ctl_mode == CTL_TORQUE) ? regs_reg[OFS_TRQ_HYS[6:2]] :
                   regs_reg[OFS_POS_HYS[6:2]];

  // monitored quantity per code; codes not offered in a mode fall back to set 1
  logic [15:0] quantity;
  logic threshold_code;
  assign quantity = (act_mode == SW_TORQUE) ? mon.torque_cmd :
                    (act_mode == SW_SPD_CHG) ? mon.speed_cmd_change :
                    (act_mode == SW_SPD_CMD) ? mon.speed_cmd :
                    (act_mode == SW_DEVIATION) ? mon.position_dev :
                    mon.speed_fb;
  assign threshold_code = (act_mode == SW_TORQUE) || (act_mode == SW_SPD_CMD) ||
                          (ctl_mode == CTL_SPEED && act_mode == SW_SPD_CHG) ||
                          (ctl_mode == CTL_POSITION && (act_mode == SW_DEVIATION ||
                           act_mode == SW_SPD_FB));

  wire [16:0] hi_thr = {1'b0, act_lvl} + {1'b0, act_hys};
  wire [16:0] lo_thr = (act_hys > act_lvl) ? 17'h0_0000 : {1'b0, act_lvl - act_hys};
  wire above = {1'b0, quantity} > hi_thr;
  wire below = {1'b0, quantity} < lo_thr;

  // demand for set 2 and condition for starting the return delay
  logic want2, may_return;
  always_comb begin
    want2 = 1'b0;
    may_return = 1'b0;
    if (threshold_code) begin
      want2 = above;
      may_return = below;
    end else if (ctl_mode == CTL_POSITION && act_mode == SW_POS_CMD) begin
      want2 = mon.pos_cmd_active;
      may_return = !mon.pos_cmd_active;
    end else if (ctl_mode == CTL_POSITION && act_mode == SW_INPOS) begin
      want2 = !mon.positioning_done;
      may_return = mon.positioning_done;
    end else if (ctl_mode == CTL_POSITION && act_mode == SW_POS_SPD) begin
      want2 = mon.pos_cmd_active;
      may_return = !mon.pos_cmd_active && (mon.speed_fb < act_lvl);
    end
  end

  // 0.1 ms tick divider for the return delay
  logic [12:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == TICK_CYC - 13'h0001);
  always_ff @(posedge aclk) begin
    if (!aresetn) tick_cnt_reg <= 13'h0000;
    else tick_cnt_reg <= tick ? 13'h0000 : tick_cnt_reg + 13'h0001;
  end

  logic set2_reg, set2_next;
  logic pi_p_reg, pi_p_next;
  logic [15:0] dly_cnt_reg, dly_cnt_next;
  wire dynamic = (act_mode >= SW_TORQUE);
  // codes with a return delay; any other code above 2 falls back to set 1
  wire timed = threshold_code || (ctl_mode == CTL_POSITION &&
               (act_mode == SW_POS_CMD || act_mode == SW_INPOS || act_mode == SW_POS_SPD));
  always_comb begin
    set2_next = set2_reg;
    dly_cnt_next = dly_cnt_reg;
    pi_p_next = 1'b0;
    if (act_mode == SW_FIX1) begin
      set2_next = 1'b0;
    end else if (act_mode == SW_FIX2) begin
      set2_next = 1'b1;
    end else if (act_mode == SW_INPUT) begin
      set2_next = in_func && mon.gain_sel_in;
      pi_p_next = !in_func && mon.gain_sel_in;
    end else if (!timed) begin
      set2_next = 1'b0;
    end else if (want2) begin
      set2_next = 1'b1;
      dly_cnt_next = 16'h0000;
    end else if (set2_reg && may_return) begin
      // held in set 2 until the whole delay has elapsed
      if (dly_cnt_reg >= act_dly) begin
        set2_next = 1'b0;
        dly_cnt_next = 16'h0000;
      end else if (tick) begin
        dly_cnt_next = dly_cnt_reg + 16'h0001;
      end
    end else begin
      dly_cnt_next = 16'h0000;
    end
  end

  // set 2 and p-only update once per control cycle; the delay count also on ticks for codes 3 and up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      set2_reg <= 1'b0;
      pi_p_reg <= 1'b0;
      dly_cnt_reg <= 16'h0000;
    end else if (cycle_strobe || (dynamic && tick)) begin
      set2_reg <= cycle_strobe ? set2_next : set2_reg;
      pi_p_reg <= cycle_strobe ? pi_p_next : pi_p_reg;
      dly_cnt_reg <= dly_cnt_next;
    end
  end

  // feedforward and observer outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_out <= '0;
      obs_live_reg <= '0;
      obs_live_reg.cutoff <= RST_OBS_CUT;
      obs_live_reg.inertia <= RST_OBS_INR;
    end else begin
      gain_out.gain_set2 <= set2_next && cycle_strobe ? 1'b1 :
                            (cycle_strobe ? set2_next : set2_reg);
      gain_out.speed_p_only <= cycle_strobe ? pi_p_next : pi_p_reg;
      gain_out.ff_source <= ff_src;
      gain_out.ff_gain <= (ff_src == FF_NONE) ? 16'h0000 : regs_reg[OFS_FF_GAIN[6:2]];
      gain_out.ff_filter_time <= regs_reg[OFS_FF_FILT[6:2]];
      gain_out.ff_external <= (ff_src == FF_EXTERNAL) ? external_torque_ff_input
                                                      : 16'h0000;
      obs_live_reg.phase_comp <= regs_reg[OFS_OBS_PH[6:2]];
      // cutoff, inertia and mode take effect only on restart
      if (restart_req) begin
        obs_live_reg.mode <= regs_reg[OFS_OBS_MODE[6:2]][1:0];
        obs_live_reg.cutoff <= regs_reg[OFS_OBS_CUT[6:2]];
        obs_live_reg.inertia <= regs_reg[OFS_OBS_INR[6:2]];
      end
    end
  end
  assign observer_out = obs_live_reg;

  // read channel, one cycle answer
  wire [7:0] ra = s_axi_araddr[7:0];
  wire rd_ok = (s_axi_araddr[31:8] == 24'h00_0000) && (ra[1:0] == 2'b00) && (ra <= OFS_RESTART);
  wire [31:0] rd_val = (ra == OFS_STATUS) ?
                       {16'h0000, dly_cnt_reg[11:0], pi_p_reg, 2'b00, set2_reg} :
                       (ra == OFS_RESTART) ? 32'h0000_0000 : {16'h0000, regs_reg[ra[6:2]]};
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_val : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_fix_one: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_strobe && act_mode == SW_FIX1 |=> !set2_reg) else $error("fixed set 1 not held");
  a_fix_two: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_strobe && act_mode == SW_FIX2 |=> set2_reg) else $error("fixed set 2 not held");
  a_input_set: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_strobe && act_mode == SW_INPUT |=> set2_reg == $past(in_func && mon.gain_sel_in))
    else $error("input select wrong");
  a_input_pi: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_strobe && act_mode == SW_INPUT && !in_func |=> !set2_reg && pi_p_reg == $past(mon.gain_sel_in))
    else $error("p/pi toggle wrong");
  a_enter_two: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_strobe && threshold_code && above |=> set2_reg) else $error("set 2 not entered");
  a_hold_hyst: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_strobe && set2_reg && threshold_code && !below |=> set2_reg)
    else $error("left set 2 inside band");
  a_src_none: assert property (@(posedge aclk) disable iff (!aresetn)
    ff_src == FF_NONE |=> gain_out.ff_gain == 16'h0000 && gain_out.ff_external == 16'h0000)
    else $error("feedforward active with none");
  a_cut_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    !restart_req |=> $stable(obs_live_reg.cutoff)) else $error("cutoff changed without restart");
  a_delay_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(set2_reg) |-> $past(dly_cnt_reg >= act_dly) || $past(!timed))
    else $error("early return");
endmodule

//--- sgs_servo_model.sv
// servo, encoder and command source model feeding the selector monitor
`timescale 1ns/1ns
module sgs_servo_model #(
  parameter int STROBE_DIV = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sgs_pkg::sgs_monitor_t target,
  output logic cycle_strobe,
  output sgs_pkg::sgs_monitor_t mon
);
  import sgs_pkg::*;
  int cnt_reg;
  // quantities move only after a control cycle, like sampled feedback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 0;
      cycle_strobe <= 1'b0;
      mon <= '0;
    end else begin
      cnt_reg <= (cnt_reg == STROBE_DIV - 1) ? 0 : cnt_reg + 1;
      cycle_strobe <= (cnt_reg == STROBE_DIV - 1);
      if (cycle_strobe) begin
        mon <= target;
      end
    end
  end
endmodule

//--- sgs_selector_bench.sv
// self-checking bench for the servo gain group selector
`timescale 1ns/1ns
module sgs_selector_bench;
  import sgs_pkg::*;
  typedef struct {string name; logic [33:0] exp; int kind;} sgs_note_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, strobe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  sgs_ctl_mode_t ctl_mode = CTL_POSITION;
  logic [15:0] ext_ff = '0;
  sgs_monitor_t tgt = '0;
  sgs_monitor_t mon;
  sgs_gain_out_t gout;
  sgs_observer_t obs;
  sgs_note_t rd_q[$], pr_q[$], wr_q[$], n;
  int failures = 0, checks_done = 0, cycles = 0;
  logic probe = 1'b0;

  always #10 aclk = ~aclk;

  sgs_servo_model #(.STROBE_DIV(20)) srv_u (.aclk(aclk), .aresetn(aresetn), .target(tgt),
    .cycle_strobe(strobe), .mon(mon));
  sgs_selector dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ctl_mode(ctl_mode), .cycle_strobe(strobe), .mon(mon),
    .external_torque_ff_input(ext_ff), .gain_out(gout), .observer_out(obs));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [33:0] seen_of(input int k);
    case (k)
      0: return 34'(gout.gain_set2);
      1: return 34'(gout.speed_p_only);
      2: return 34'(gout.ff_source);
      3: return 34'(gout.ff_gain);
      4: return 34'(gout.ff_external);
      6: return 34'(gout.ff_filter_time);
      7: return {obs.mode, obs.phase_comp, obs.inertia};
      default: return 34'(obs.cutoff);
    endcase
  endfunction

  function automatic logic [33:0] ok(input logic [15:0] v);
    return {18'h0_0000, v};
  endfunction

  // watcher: results are taken where they appear, oldest note first
  always @(posedge aclk) begin
    cycles++;
    if (rvalid && rready && rd_q.size() > 0) begin
      n = rd_q.pop_front();
      check(n.name, {rresp, rdata}, n.exp);
    end
    if (bvalid && bready && wr_q.size() > 0) begin
      n = wr_q.pop_front();
      check(n.name, 34'(bresp), n.exp);
    end
    if (probe && pr_q.size() > 0) begin
      n = pr_q.pop_front();
      check(n.name, seen_of(n.kind), n.exp);
    end
    if (cycles == 50000) begin
      failures++;
      end_sim();
    end
  end

  task automatic expect_out(input string name, input int kind, input logic [33:0] exp);
    pr_q.push_back('{name, exp, kind});
    probe <= 1'b1;
    @(posedge aclk);
    probe <= 1'b0;
    @(posedge aclk);
  endtask

  // selection moves only on strobes, so wait whole control cycles
  task automatic cyc(input int k);
    repeat (k) begin
      @(posedge aclk);
      while (!strobe) @(posedge aclk);
    end
    repeat (3) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wr_q.push_back('{"bresp", (a > OFS_RESTART) ? 34'(2'b10) : 34'(0), 0});
    awaddr <= {24'h00_0000, a};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [33:0] exp);
    rd_q.push_back('{name, exp, 0});
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic setq(input int f, input logic [15:0] v);
    case (f)
      0: tgt.torque_cmd <= v;
      1: tgt.speed_cmd <= v;
      2: tgt.speed_cmd_change <= v;
      3: tgt.position_dev <= v;
      default: tgt.speed_fb <= v;
    endcase
  endtask

  // both edges of the hysteresis band, each side of the boundary
  task automatic thr(input string name, input sgs_ctl_mode_t m, input logic [7:0] b,
    input logic [3:0] code, input int f);
    logic [15:0] l, h;
    logic [15:0] qs [4];
    l = 16'(200 + $urandom_range(800));
    h = 16'(1 + $urandom_range(49));
    qs = '{l + h, l + h + 16'h0001, l - h, l - h - 16'h0001};
    ctl_mode <= m;
    tgt <= '0;
    wr(b, 16'(code));
    wr(b + 8'h04, 16'h0000);
    wr(b + 8'h08, l);
    wr(b + 8'h0c, h);
    cyc(3);
    for (int i = 0; i < 4; i++) begin
      setq(f, qs[i]);
      cyc(3);
      expect_out(name, 0, 34'(i == 1 || i == 2));
    end
    $display("test %s done", name);
  endtask

  task automatic step(input string name, input logic a, input logic d, input logic [15:0] fb,
    input logic e);
    tgt.pos_cmd_active <= a;
    tgt.positioning_done <= d;
    tgt.speed_fb <= fb;
    cyc(3);
    expect_out(name, 0, 34'(e));
  endtask

  initial begin
    void'($urandom(32'h0000_4318));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd("pos_delay", OFS_POS_DLY, ok(RST_POS_DLY));
    rd("pos_level", OFS_POS_LVL, ok(RST_POS_LVL));
    rd("spd_delay", OFS_SPD_DLY, ok(16'h0000));
    rd("trq_level", OFS_TRQ_LVL, ok(16'h0000));
    rd("ff_filter", OFS_FF_FILT, ok(16'h0000));
    rd("obs_inertia", OFS_OBS_INR, ok(RST_OBS_INR));
    rd("unmapped", 8'h5c, {2'b10, 32'h0000_0000});
    expect_out("obs_cutoff", 5, 34'(RST_OBS_CUT));
    expect_out("obs_reset", 7, {2'b00, 16'h0000, RST_OBS_INR});
    wr(8'h5c, 16'h1234);
    $display("test reset_values done");
    wr(OFS_FF_GAIN, 16'hffff);
    rd("ff_gain_sat", OFS_FF_GAIN, ok(MAX_FF_GAIN));
    wr(OFS_FF_FILT, 16'h1901);
    rd("ff_filt_sat", OFS_FF_FILT, ok(MAX_FF_FILT));
    expect_out("ff_filter_out", 6, 34'(MAX_FF_FILT));
    wr(OFS_TRQ_MODE, 16'h0007);
    rd("trq_mode_sat", OFS_TRQ_MODE, ok(MAX_TRQ_MODE));
    wr(OFS_POS_LVL, 16'h4e21);
    rd("pos_lvl_sat", OFS_POS_LVL, ok(MAX_LVL));
    $display("test saturation done");
    wr(OFS_FF_GAIN, 16'h012c);
    for (int s = 0; s < 3; s++) begin
      ext_ff <= 16'($urandom);
      wr(OFS_SOURCE, 16'(s));
      cyc(1);
      expect_out("ff_source", 2, 34'(s));
      expect_out("ff_gain", 3, (s == 0) ? 34'(0) : 34'(16'h012c));
      expect_out("ff_external", 4, (s == 2) ? 34'(ext_ff) : 34'(0));
    end
    $display("test ff_source done");
    thr("pos_torque", CTL_POSITION, OFS_POS_MODE, SW_TORQUE, 0);
    thr("pos_speed", CTL_POSITION, OFS_POS_MODE, SW_SPD_CMD, 1);
    thr("pos_dev", CTL_POSITION, OFS_POS_MODE, SW_DEVIATION, 3);
    thr("pos_fb", CTL_POSITION, OFS_POS_MODE, SW_SPD_FB, 4);
    thr("spd_torque", CTL_SPEED, OFS_SPD_MODE, SW_TORQUE, 0);
    thr("spd_change", CTL_SPEED, OFS_SPD_MODE, SW_SPD_CHG, 2);
    thr("spd_cmd", CTL_SPEED, OFS_SPD_MODE, SW_SPD_CMD, 1);
    thr("trq_torque", CTL_TORQUE, OFS_TRQ_MODE, SW_TORQUE, 0);
    for (int c = 0; c < 2; c++) begin
      ctl_mode <= CTL_POSITION;
      wr(OFS_POS_MODE, 16'(c));
      cyc(3);
      expect_out("fixed_set", 0, 34'(c));
    end
    wr(OFS_POS_MODE, 16'h0004);
    cyc(3);
    expect_out("unoffered", 0, 34'(0));
    ctl_mode <= CTL_SPEED;
    wr(OFS_SPD_MODE, 16'h0000);
    cyc(3);
    expect_out("other_mode", 0, 34'(0));
    $display("test fixed_modes done");
    ctl_mode <= CTL_POSITION;
    wr(OFS_POS_MODE, 16'(SW_INPUT));
    for (int k = 0; k < 4; k++) begin
      wr(OFS_IN_FUNC, 16'(k / 2));
      tgt.gain_sel_in <= k[0];
      cyc(3);
      expect_out("input_set", 0, 34'(k == 3));
      expect_out("input_p_only", 1, 34'(k == 1));
    end
    $display("test select_input done");
    wr(OFS_POS_MODE, 16'(SW_POS_CMD));
    step("cmd_active", 1'b1, 1'b1, 16'h0000, 1'b1);
    step("cmd_idle", 1'b0, 1'b1, 16'h0000, 1'b0);
    wr(OFS_POS_MODE, 16'(SW_INPOS));
    step("not_done", 1'b0, 1'b0, 16'h0000, 1'b1);
    step("done", 1'b0, 1'b1, 16'h0000, 1'b0);
    wr(OFS_POS_MODE, 16'(SW_POS_SPD));
    wr(OFS_POS_LVL, 16'h0064);
    wr(OFS_POS_HYS, 16'h0000);
    step("ps_active", 1'b1, 1'b1, 16'h0000, 1'b1);
    step("ps_fast", 1'b0, 1'b1, 16'h00c8, 1'b1);
    step("ps_slow", 1'b0, 1'b1, 16'h0000, 1'b0);
    $display("test activity_codes done");
    // two ticks of return delay is 10000 clocks, 20 clocks per strobe
    wr(OFS_POS_MODE, 16'(SW_POS_CMD));
    wr(OFS_POS_DLY, 16'h0002);
    step("dly_enter", 1'b1, 1'b1, 16'h0000, 1'b1);
    rd("status_set2", OFS_STATUS, ok(16'h0001));
    tgt.pos_cmd_active <= 1'b0;
    cyc(100);
    expect_out("dly_hold", 0, 34'(1));
    cyc(500);
    expect_out("dly_return", 0, 34'(0));
    $display("test return_delay done");
    wr(OFS_OBS_CUT, 16'h00c8);
    wr(OFS_OBS_MODE, 16'h0002);
    wr(OFS_OBS_PH, 16'h0010);
    wr(OFS_OBS_INR, 16'h0400);
    cyc(1);
    expect_out("cut_before", 5, 34'(RST_OBS_CUT));
    expect_out("obs_before", 7, {2'b00, 16'h0010, RST_OBS_INR});
    wr(OFS_RESTART, 16'h0001);
    cyc(1);
    expect_out("cut_after", 5, 34'(16'h00c8));
    expect_out("obs_after", 7, {2'b10, 16'h0010, 16'h0400});
    $display("test restart done");
    end_sim();
  end
endmodule
